// file: rtl/mmcs_pkg.sv
// constants, map and types for the module management control and status block
package mmcs_pkg;
  // clock and timing
  localparam int CLK_MHZ = 100;
  localparam int INIT_TIME_MS = 2000;
  localparam int INIT_CYC = INIT_TIME_MS * 1000 * CLK_MHZ;
  localparam int RST_MIN_US = 2;
  localparam int RST_MIN_CYC = RST_MIN_US * CLK_MHZ;
  // two-wire address, 8-bit form 0xa0
  localparam logic [6:0] DEV_ADDR = 7'h50;
  // lower page byte offsets
  localparam logic [7:0] OFS_STATUS = 8'h02;
  localparam logic [7:0] OFS_FLAGS = 8'h03;
  localparam logic [7:0] OFS_PWR = 8'h5d;
  localparam logic [7:0] OFS_MASK = 8'h64;
  localparam logic [7:0] OFS_PAGE = 8'h7f;
  // field positions
  localparam int NRDY_BIT = 0;
  localparam int PDOWN_BIT = 0;
  localparam int LOS_BIT = 0;
  localparam int INIT_BIT = 7;
  // reset values
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] PAGE_RST = 8'h00;
  localparam logic [4:0] SYNC_RST = 5'h0f;
  // memory shape
  localparam int PAGE_BYTES = 128;
  localparam int UPPER_PAGES = 3;
  localparam int MEM_AW = 9;
  // two-wire slave states
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ACKA, ST_WR, ST_ACKW, ST_RD, ST_MACK
  } mmcs_state_t;
endpackage

// file: rtl/mmcs_mem_if.sv
// port between the management logic and its byte memory
`timescale 1ns/1ns
`default_nettype none
interface mmcs_mem_if #(parameter int AW = 9);
  logic we;
  logic [AW-1:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport ctl (output we, output addr, output wdata, input rdata);
  modport mem (input we, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// file: rtl/mmcs_mem.sv
// byte memory for lower and upper pages, registered read
`timescale 1ns/1ns
`default_nettype none
module mmcs_mem #(
  parameter int AW = 9,
  parameter int DEPTH = 512
) (
  // clock
  input wire logic sys_clk_in,
  // access port
  mmcs_mem_if.mem port
);
  logic [7:0] ram [DEPTH];

  // write and registered read; no reset so it maps onto block ram
  always_ff @(posedge sys_clk_in) begin
    if (port.we) begin
      ram[port.addr] <= port.wdata;
    end
    port.rdata <= ram[port.addr];
  end
endmodule
`default_nettype wire

// file: rtl/mmcs_top.sv
// management control and status: two-wire slave, flags, mask, power and reset pins
`timescale 1ns/1ns
`default_nettype none
// Function
// [R1] lower page of 128 bytes always addressable, plus several upper pages
// [R2] identification and thresholds sit in upper pages chosen by page select
// [R3] flags and monitors live in lower page for one-read interrupt service
// [R4] answer on the two-wire bus at device address 0xa0
// [R5] host reads flag field after interrupt goes low to find its cause
// [R6] fully functional within 2000 ms of power-on or reset pin rising
// [R7] reset pin low longer than 2 us is taken as a reset
// [R8] answer bus transfers within 2000 ms of power-on
// [R9] within 2000 ms clear data-not-ready bit and assert interrupt
// [R10] low-power pin high cuts power within 100 us
// [R11] interrupt condition drives interrupt low within 200 ms
// [R12] reading a flag clears it; interrupt released within 500 us
// [R13] loss-of-signal sets its flag and interrupt within 100 ms
// [R14] any other condition sets its flag and interrupt within 200 ms
// [R15] mask bit set stops interrupt for its flag within 100 ms
// [R16] mask bit cleared resumes interrupt for its flag within 100 ms
// [R17] select pin low enables bus answers within 100 us
// [R18] select pin high stops bus answers within 100 us
// [R19] power-down bit set cuts power within 100 ms
// [R20] power-down bit cleared returns to full function within 300 ms
// [R21] write effects timed from the write's stop condition
// [R22] flags stay set after condition clears until host reads them
module mmcs_top #(
  parameter int INIT_CYC = mmcs_pkg::INIT_CYC,
  parameter int FLAG_W = 7
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // two-wire bus
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  // control pins
  input wire logic module_reset_n_in,
  input wire logic module_select_n_in,
  input wire logic low_power_pin_in,
  output logic interrupt_out_n_out,
  // module core
  input wire logic [FLAG_W-1:0] flag_cond_in,
  output logic low_power_out,
  output logic ready_out
);
  mmcs_mem_if #(.AW(mmcs_pkg::MEM_AW)) mif ();

  mmcs_mem #(
    .AW(mmcs_pkg::MEM_AW),
    .DEPTH((mmcs_pkg::UPPER_PAGES + 1) * mmcs_pkg::PAGE_BYTES)
  ) u_mem (
    .sys_clk_in(sys_clk_in),
    .port(mif.mem)
  );

  // synchronisers: {lp, sel_n, rst_n, sda, scl}
  logic [4:0] s1_r;
  logic [4:0] s2_r;
  logic scl_d_r;
  logic sda_d_r;
  logic scl_s, sda_s, mrst_n_s, sel_n_s, lp_s;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      s1_r <= mmcs_pkg::SYNC_RST;
      s2_r <= mmcs_pkg::SYNC_RST;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      s1_r <= {low_power_pin_in, module_select_n_in, module_reset_n_in, sda_in, scl_in};
      s2_r <= s1_r;
      scl_d_r <= s2_r[0];
      sda_d_r <= s2_r[1];
    end
  end

  assign scl_s = s2_r[0];
  assign sda_s = s2_r[1];
  assign mrst_n_s = s2_r[2];
  assign sel_n_s = s2_r[3];
  assign lp_s = s2_r[4];

  // bus events; the link clock is sampled, edges found by comparison
  logic scl_rise, scl_fall, start_c, stop_c;
  assign scl_rise = scl_s & ~scl_d_r;
  assign scl_fall = ~scl_s & scl_d_r;
  assign start_c = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop_c = scl_s & scl_d_r & ~sda_d_r & sda_s;

  // reset pin qualifier: a glitch shorter than the minimum pulse is ignored
  logic [15:0] rlow_cnt_r;
  logic hold_r;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rlow_cnt_r <= 16'h0000;
      hold_r <= 1'b0;
    end else if (mrst_n_s) begin
      rlow_cnt_r <= 16'h0000;
      hold_r <= 1'b0; // rising edge restarts initialisation [R6]
    end else if (rlow_cnt_r >= 16'(mmcs_pkg::RST_MIN_CYC)) begin
      hold_r <= 1'b1; // low longer than minimum is a reset [R7]
    end else begin
      rlow_cnt_r <= rlow_cnt_r + 16'h0001;
    end
  end

  // initialisation timer, restarted by power-on and by the reset pin
  logic [31:0] init_cnt_r;
  logic not_ready_r;
  logic init_evt;
  assign init_evt = not_ready_r & ~hold_r & (init_cnt_r == 32'(INIT_CYC - 1));

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      init_cnt_r <= 32'h0000_0000;
      not_ready_r <= 1'b1;
    end else if (hold_r) begin
      init_cnt_r <= 32'h0000_0000;
      not_ready_r <= 1'b1;
    end else if (init_evt) begin
      not_ready_r <= 1'b0; // data-not-ready drops at the end of init [R6] [R9]
    end else if (not_ready_r) begin
      init_cnt_r <= init_cnt_r + 32'h0000_0001;
    end
  end

  // two-wire slave
  mmcs_pkg::mmcs_state_t st_r;
  logic [3:0] cnt_r;
  logic [7:0] sh_r;
  logic rw_r;
  logic first_r;
  logic sda_oe_r;
  logic sda_lvl_r;
  logic [7:0] ptr_r;
  logic bus_en;
  logic wr_evt, rd_load;
  logic [7:0] rd_byte;
  logic [7:0] flags_r;
  logic [7:0] mask_r;
  logic [7:0] page_r;
  logic pdown_r;

  assign bus_en = ~sel_n_s & ~hold_r; // select gates all bus answers [R8] [R17] [R18]
  assign wr_evt = (st_r == mmcs_pkg::ST_WR) & scl_fall & (cnt_r == 4'h8);
  assign rd_load = scl_fall & (((st_r == mmcs_pkg::ST_ACKA) & rw_r) | (st_r == mmcs_pkg::ST_MACK));

  // read data: live registers first, everything else from memory
  always_comb begin
    case (ptr_r)
      mmcs_pkg::OFS_STATUS: rd_byte = {7'h00, not_ready_r};
      mmcs_pkg::OFS_FLAGS: rd_byte = flags_r; // flags sit in the lower page [R3]
      mmcs_pkg::OFS_MASK: rd_byte = mask_r;
      mmcs_pkg::OFS_PWR: rd_byte = {7'h00, pdown_r};
      mmcs_pkg::OFS_PAGE: rd_byte = page_r;
      default: rd_byte = mif.rdata;
    endcase
  end

  // lower page at slot 0, upper half goes to the selected page [R1] [R2]
  assign mif.addr = ptr_r[7] ? {page_r[1:0] + 2'b01, ptr_r[6:0]} : {2'b00, ptr_r[6:0]};
  assign mif.we = wr_evt & ~first_r;
  assign mif.wdata = sh_r;

  // protocol state; data changes only while clock is low
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_r <= mmcs_pkg::ST_IDLE;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      rw_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else if (!bus_en || stop_c) begin
      st_r <= mmcs_pkg::ST_IDLE; // deselect drops the transfer at once [R18]
      sda_oe_r <= 1'b0;
    end else if (start_c) begin
      st_r <= mmcs_pkg::ST_ADDR;
      cnt_r <= 4'h0;
      sda_oe_r <= 1'b0;
    end else begin
      case (st_r)
        mmcs_pkg::ST_ADDR: begin
          if (scl_rise) begin
            sh_r <= {sh_r[6:0], sda_s};
            cnt_r <= cnt_r + 4'h1;
          end else if (scl_fall && cnt_r == 4'h8) begin
            cnt_r <= 4'h0;
            if (sh_r[7:1] == mmcs_pkg::DEV_ADDR) begin
              st_r <= mmcs_pkg::ST_ACKA; // own address only [R4]
              rw_r <= sh_r[0];
              sda_oe_r <= 1'b1;
            end else begin
              st_r <= mmcs_pkg::ST_IDLE;
            end
          end
        end
        mmcs_pkg::ST_ACKA: begin
          if (scl_fall) begin
            if (rw_r) begin
              st_r <= mmcs_pkg::ST_RD;
              sh_r <= rd_byte;
              sda_oe_r <= ~rd_byte[7];
            end else begin
              st_r <= mmcs_pkg::ST_WR;
              sda_oe_r <= 1'b0;
            end
          end
        end
        mmcs_pkg::ST_WR: begin
          if (scl_rise) begin
            sh_r <= {sh_r[6:0], sda_s};
            cnt_r <= cnt_r + 4'h1;
          end else if (wr_evt) begin
            st_r <= mmcs_pkg::ST_ACKW;
            cnt_r <= 4'h0;
            sda_oe_r <= 1'b1;
          end
        end
        mmcs_pkg::ST_ACKW: begin
          if (scl_fall) begin
            st_r <= mmcs_pkg::ST_WR;
            sda_oe_r <= 1'b0;
          end
        end
        mmcs_pkg::ST_RD: begin
          if (scl_rise) begin
            cnt_r <= cnt_r + 4'h1;
          end else if (scl_fall) begin
            if (cnt_r == 4'h8) begin
              st_r <= mmcs_pkg::ST_MACK;
              cnt_r <= 4'h0;
              sda_oe_r <= 1'b0;
            end else begin
              sh_r <= {sh_r[6:0], 1'b0};
              sda_oe_r <= ~sh_r[6];
            end
          end
        end
        mmcs_pkg::ST_MACK: begin
          if (scl_rise && sda_s) begin
            st_r <= mmcs_pkg::ST_IDLE; // master nack ends the read
          end else if (scl_fall) begin
            st_r <= mmcs_pkg::ST_RD;
            sh_r <= rd_byte;
            sda_oe_r <= ~rd_byte[7];
          end
        end
        default: begin
          st_r <= mmcs_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // byte pointer: first written byte sets it, every data byte advances it
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ptr_r <= 8'h00;
      first_r <= 1'b0;
    end else if (start_c) begin
      first_r <= 1'b1;
    end else if (wr_evt && first_r) begin
      ptr_r <= sh_r;
      first_r <= 1'b0;
    end else if (wr_evt || rd_load) begin
      ptr_r <= ptr_r + 8'h01;
      first_r <= 1'b0;
    end
  end

  // writable control bytes; a write lands before the stop, well inside the limits [R21]
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      mask_r <= mmcs_pkg::MASK_RST;
      page_r <= mmcs_pkg::PAGE_RST;
      pdown_r <= 1'b0;
    end else if (hold_r) begin
      mask_r <= mmcs_pkg::MASK_RST;
      page_r <= mmcs_pkg::PAGE_RST;
      pdown_r <= 1'b0;
    end else if (wr_evt && !first_r) begin
      if (ptr_r == mmcs_pkg::OFS_MASK) begin
        mask_r <= sh_r; // mask bits [R15] [R16]
      end
      if (ptr_r == mmcs_pkg::OFS_PWR) begin
        pdown_r <= sh_r[mmcs_pkg::PDOWN_BIT]; // [R19] [R20]
      end
      if (ptr_r == mmcs_pkg::OFS_PAGE && sh_r < 8'(mmcs_pkg::UPPER_PAGES)) begin
        page_r <= sh_r; // out-of-range page numbers are ignored [R2]
      end
    end
  end

  // latched flags: a new event in the clearing cycle survives the clear
  logic [7:0] flag_set;
  logic [7:0] flag_clr;
  assign flag_set = {init_evt, flag_cond_in}; // los is bit 0 [R13] [R14] [R9]
  assign flag_clr = (rd_load && ptr_r == mmcs_pkg::OFS_FLAGS) ? flags_r : 8'h00;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      flags_r <= mmcs_pkg::FLAGS_RST;
    end else if (hold_r) begin
      flags_r <= mmcs_pkg::FLAGS_RST;
    end else begin
      flags_r <= (flags_r & ~flag_clr) | flag_set; // sticky, clear on read [R12] [R22]
    end
  end

  // registered pin outputs; every path here is a couple of cycles
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      interrupt_out_n_out <= 1'b1;
      low_power_out <= 1'b0;
      ready_out <= 1'b0;
      sda_lvl_r <= 1'b0;
    end else begin
      interrupt_out_n_out <= ~|(flags_r & ~mask_r); // [R11] [R12] [R15] [R16]
      low_power_out <= lp_s | pdown_r; // [R10] [R19]
      ready_out <= ~not_ready_r & ~pdown_r; // [R20]
      sda_lvl_r <= 1'b0;
    end
  end

  assign sda_out = sda_lvl_r;
  assign sda_oe_out = sda_oe_r;

  // checks
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  property p_irq_on;
    (|(flags_r & ~mask_r)) |=> !interrupt_out_n_out;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("interrupt not asserted"); // [R11]

  property p_irq_off;
    !(|(flags_r & ~mask_r)) |=> interrupt_out_n_out;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("interrupt not released"); // [R12]

  property p_los_set;
    flag_cond_in[mmcs_pkg::LOS_BIT] && !hold_r |=> flags_r[mmcs_pkg::LOS_BIT] ##1 !interrupt_out_n_out || mask_r[0];
  endproperty
  a_los_set: assert property (p_los_set) else $error("los flag not raised"); // [R13]

  property p_flag_hold;
    flags_r[1] && !hold_r && !(rd_load && ptr_r == mmcs_pkg::OFS_FLAGS) |=> flags_r[1];
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag lost without read"); // [R22]

  property p_clr_read;
    rd_load && ptr_r == mmcs_pkg::OFS_FLAGS && !flag_cond_in[2] |=> !flags_r[2];
  endproperty
  a_clr_read: assert property (p_clr_read) else $error("flag not cleared by read"); // [R12]

  // flags pending but every one of them masked: the pin must stay released
  property p_mask_all;
    ((|flags_r) && ((flags_r & ~mask_r) == 8'h00)) [*2] |-> interrupt_out_n_out;
  endproperty
  a_mask_all: assert property (p_mask_all) else $error("masked interrupt seen"); // [R15]

  property p_lowpower;
    (lp_s || pdown_r) |=> low_power_out;
  endproperty
  a_lowpower: assert property (p_lowpower) else $error("low power not entered"); // [R10]

  property p_deselect;
    sel_n_s |=> st_r == mmcs_pkg::ST_IDLE && !sda_oe_out;
  endproperty
  a_deselect: assert property (p_deselect) else $error("answer while deselected"); // [R18]

  property p_init_done;
    init_evt |=> !not_ready_r && flags_r[mmcs_pkg::INIT_BIT] ##1 (!interrupt_out_n_out || mask_r[7]);
  endproperty
  a_init_done: assert property (p_init_done) else $error("init completion not signalled"); // [R9]

  // own count of synced low cycles, kept apart from the qualifier so the check is not circular
  logic [15:0] chk_low_r;
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      chk_low_r <= 16'h0000;
    end else if (mrst_n_s) begin
      chk_low_r <= 16'h0000;
    end else if (chk_low_r != 16'hffff) begin
      chk_low_r <= chk_low_r + 16'h0001;
    end
  end

  property p_rst_short;
    $rose(hold_r) |-> chk_low_r > 16'(mmcs_pkg::RST_MIN_CYC);
  endproperty
  a_rst_short: assert property (p_rst_short) else $error("short reset pulse acted"); // [R7]

  c_addr_ack: cover property (st_r == mmcs_pkg::ST_ACKA && rw_r);
  c_flag_read: cover property (rd_load && ptr_r == mmcs_pkg::OFS_FLAGS && flags_r != 8'h00);
  c_mask_write: cover property (wr_evt && !first_r && ptr_r == mmcs_pkg::OFS_MASK);
  c_pin_reset: cover property ($rose(hold_r));
endmodule
`default_nettype wire

// file: tb/mmcs_host_model.sv
// host controller model: bit-banged two-wire master with a 125 ns bus period
`timescale 1ns/1ns
`default_nettype none
module mmcs_host_model (
  // two-wire pins, released level is high through the pull-up
  output var logic scl_out,
  output var logic sda_out,
  // resolved data line
  input wire logic sda_in
);
  // clock stands high between frames, it never runs free
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end

  // start or repeated start, entered from idle or with the clock low
  task automatic start_cond();
    #31 sda_out = 1'b1;
    #32 scl_out = 1'b1;
    #62 sda_out = 1'b0;
    #62 scl_out = 1'b0;
  endtask

  // one bit each way: data moves in the low half, sampled mid-high
  task automatic bit_xfer(input logic b, output logic r);
    #31 sda_out = b;
    #32 scl_out = 1'b1;
    #31 r = sda_in;
    #31 scl_out = 1'b0;
  endtask

  task automatic stop_cond();
    #31 sda_out = 1'b0;
    #32 scl_out = 1'b1;
    #62 sda_out = 1'b1;
    #62;
  endtask

  // byte out msb first, then the device's acknowledge
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(b[i], r);
    end
    bit_xfer(1'b1, r);
    ack = ~r;
  endtask

  // one byte in, then a nack so the read ends cleanly
  task automatic get_byte(output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, r);
      b[i] = r;
    end
    bit_xfer(1'b1, r);
  endtask

  // pointer write then one data byte, or a repeated start and one read byte
  task automatic xfer(input logic [7:0] adr, input logic [7:0] ptr, input logic [7:0] wd, input logic rd,
                      output logic [7:0] rdat, output logic ok);
    logic a0;
    logic a1;
    logic a2;
    rdat = 8'h00;
    start_cond();
    put_byte(adr, a0);
    put_byte(ptr, a1);
    if (rd) begin
      start_cond();
      put_byte(adr | 8'h01, a2);
      get_byte(rdat);
    end else begin
      put_byte(wd, a2);
    end
    stop_cond();
    ok = a0 & a1 & a2;
  endtask
endmodule
`default_nettype wire

// file: tb/mmcs_top_tb.sv
// self-checking bench for the management control and status block
`timescale 1ns/1ns
`default_nettype none
module mmcs_top_tb;
  localparam int INIT = 1000;
  localparam logic [7:0] ADR = {mmcs_pkg::DEV_ADDR, 1'b0};
  logic clk = 1'b0;
  logic rst;
  logic scl;
  logic host_sda;
  logic sda_drv;
  logic sda_oe;
  logic rst_n;
  logic sel_n;
  logic lp_pin;
  logic int_n;
  logic lp_out;
  logic ready;
  logic [6:0] flag_cond;
  wire logic sda_line;
  logic [8:0] exp_q[$];
  logic [8:0] got_q[$];
  int failures = 0;
  int samples_checked = 0;
  event noted;

  // open-drain data line: low if either side pulls it
  assign sda_line = host_sda & ~(sda_oe & ~sda_drv);

  always #5 clk = ~clk;

  mmcs_top #(.INIT_CYC(INIT), .FLAG_W(7)) mmcs_top_inst (
    .sys_clk_in(clk), .rst_in(rst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_drv),
    .sda_oe_out(sda_oe), .module_reset_n_in(rst_n), .module_select_n_in(sel_n),
    .low_power_pin_in(lp_pin), .interrupt_out_n_out(int_n), .flag_cond_in(flag_cond),
    .low_power_out(lp_out), .ready_out(ready));

  mmcs_host_model mmcs_host_model_inst (.scl_out(scl), .sda_out(host_sda), .sda_in(sda_line));

  task automatic print_verdict();
    if (failures == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic note(input logic [8:0] e, input logic [8:0] g);
    exp_q.push_back(e);
    got_q.push_back(g);
    -> noted;
  endtask

  // observer: oldest expectation against oldest result
  initial begin
    logic [8:0] e;
    logic [8:0] g;
    forever begin
      @(noted);
      while (got_q.size() > 0) begin
        e = exp_q.pop_front();
        g = got_q.pop_front();
        samples_checked++;
        if (g !== e) begin
          failures++;
          $display("CHECK FAILED t=%0t expected %h got %h", $time, e, g);
        end
      end
    end
  end

  // bus access; read data only counts when the device acknowledged
  task automatic acc(input logic [7:0] adr, input logic [7:0] ptr, input logic [7:0] wd, input logic rd,
                     input logic eok, input logic [7:0] ed, input logic [7:0] msk);
    logic [7:0] d;
    logic ok;
    mmcs_host_model_inst.xfer(adr, ptr, wd, rd, d, ok);
    note({eok, ed & msk}, {ok, (ok & rd) ? (d & msk) : 8'h00});
  endtask

  task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
    acc(ADR, ptr, d, 1'b0, 1'b1, 8'h00, 8'h00);
  endtask

  task automatic rd(input logic [7:0] ptr, input logic [7:0] e);
    acc(ADR, ptr, 8'h00, 1'b1, 1'b1, e, 8'hff);
  endtask

  function automatic logic cur(input int which);
    case (which)
      0: return int_n;
      1: return ready;
      default: return lp_out;
    endcase
  endfunction

  // pin level within a bounded number of cycles; lim 0 checks right now
  task automatic pin(input int which, input logic v, input int lim);
    int n;
    n = 0;
    while (cur(which) !== v && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    note({8'h00, v}, {8'h00, cur(which)});
  endtask

  // one-cycle condition pulse, gone before the flag is read
  task automatic fire(input logic [6:0] p);
    @(posedge clk);
    #1 flag_cond = p;
    @(posedge clk);
    #1 flag_cond = 7'h00;
  endtask

  task automatic drive_at_edge(ref logic s, input logic v);
    @(posedge clk);
    #1 s = v;
  endtask

  // watchdog: whole run needs well under a quarter of this
  initial begin
    #1_000_000;
    failures++;
    $display("CHECK FAILED t=%0t run did not finish", $time);
    print_verdict();
  end

  initial begin
    logic [6:0] p;
    logic [6:0] m;
    logic [7:0] a;
    rst = 1'b1;
    rst_n = 1'b1;
    sel_n = 1'b0;
    lp_pin = 1'b0;
    flag_cond = 7'h00;
    void'($urandom(32'h3306));
    repeat (5) @(posedge clk);
    #1 rst = 1'b0;
    pin(0, 1'b1, 0);
    pin(1, 1'b0, 0);
    repeat (4) @(posedge clk);
    // answers while still initialising, data-not-ready still set
    acc(ADR, mmcs_pkg::OFS_STATUS, 8'h00, 1'b1, 1'b1, 8'h01, 8'h01);
    pin(1, 1'b1, INIT);
    pin(0, 1'b0, 4);
    acc(ADR, mmcs_pkg::OFS_STATUS, 8'h00, 1'b1, 1'b1, 8'h00, 8'h01);
    rd(mmcs_pkg::OFS_FLAGS, 8'h80);
    pin(0, 1'b1, 4);
    rd(mmcs_pkg::OFS_FLAGS, 8'h00);
    // every condition input, with random companions
    for (int i = 0; i < 7; i++) begin
      p = 7'(1 << i) | 7'($urandom);
      fire(p);
      pin(0, 1'b0, 4);
      rd(mmcs_pkg::OFS_FLAGS, {1'b0, p});
      pin(0, 1'b1, 4);
    end
    // masked flags stay silent until the mask is lifted
    m = 7'($urandom) | 7'h01;
    wr(mmcs_pkg::OFS_MASK, {1'b0, m});
    fire(m);
    repeat (6) @(posedge clk);
    #1;
    pin(0, 1'b1, 0);
    rd(mmcs_pkg::OFS_MASK, {1'b0, m});
    wr(mmcs_pkg::OFS_MASK, 8'h00);
    pin(0, 1'b0, 4);
    rd(mmcs_pkg::OFS_FLAGS, {1'b0, m});
    pin(0, 1'b1, 4);
    // select gating and a foreign address
    drive_at_edge(sel_n, 1'b1);
    acc(ADR, mmcs_pkg::OFS_PAGE, 8'h00, 1'b1, 1'b0, 8'h00, 8'h00);
    drive_at_edge(sel_n, 1'b0);
    rd(mmcs_pkg::OFS_PAGE, mmcs_pkg::PAGE_RST);
    acc(ADR ^ 8'h02, 8'h00, 8'h00, 1'b0, 1'b0, 8'h00, 8'h00);
    // low-power pin and power-down bit
    drive_at_edge(lp_pin, 1'b1);
    pin(2, 1'b1, 6);
    drive_at_edge(lp_pin, 1'b0);
    pin(2, 1'b0, 6);
    wr(mmcs_pkg::OFS_PWR, 8'h01);
    pin(2, 1'b1, 4);
    pin(1, 1'b0, 4);
    wr(mmcs_pkg::OFS_PWR, 8'h00);
    pin(1, 1'b1, 4);
    pin(2, 1'b0, 4);
    // upper pages behind the page byte, lower page unaffected
    a = 8'($urandom);
    wr(8'h10, {1'b1, m});
    wr(mmcs_pkg::OFS_PAGE, 8'h01);
    wr(8'h80, a);
    wr(mmcs_pkg::OFS_PAGE, 8'h02);
    wr(8'h80, ~a);
    rd(8'h80, ~a);
    wr(mmcs_pkg::OFS_PAGE, 8'h01);
    rd(8'h80, a);
    // a page number past the last upper page is refused, selection unchanged
    wr(mmcs_pkg::OFS_PAGE, 8'h03);
    rd(mmcs_pkg::OFS_PAGE, 8'h01);
    rd(8'h10, {1'b1, m});
    // short reset pulse is ignored, a long one resets
    drive_at_edge(rst_n, 1'b0);
    repeat (50) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (8) @(posedge clk);
    #1;
    pin(1, 1'b1, 0);
    drive_at_edge(rst_n, 1'b0);
    repeat (190) @(posedge clk);
    #1;
    pin(1, 1'b0, 30);
    repeat (4) @(posedge clk);
    #1 rst_n = 1'b1;
    pin(1, 1'b1, INIT + 10);
    rd(mmcs_pkg::OFS_PAGE, mmcs_pkg::PAGE_RST);
    rd(mmcs_pkg::OFS_FLAGS, 8'h80);
    #1;
    print_verdict();
  end
endmodule
`default_nettype wire
